// >>> hdl/amg_regs.sv
// Purpose: mixer path gain register bank with decoded gain outputs
// Assumes: requests synchronous to mclk, one request per cycle at most
// Notes: decoded outputs follow the stored codes in the same edge
// Contract
// - left out mixer bits 11:9 third left aux
// - left out mixer bits 7:5 right amp
// - left out mixer bits 3:1 left amp
// - right out mixer bits 15:13 third right aux
// - right out mixer bits 7:5 right amp
// - right out mixer bits 3:1 left amp
// - record mixer bits 11:9 third left aux
// - record mixer bits 3:1 second left aux
// - code 000 cuts, 001 -12dB, 111 +6dB
// - record mixer bit 0 adds 20dB boost
`default_nettype none

module amg_regs
   import amg_pkg::*;
(
   input wire logic mclk, // 200 MHz clock
   input wire logic rst, // synchronous reset, high
   input wire logic ce, // clock enable, low freezes all state unless rst is high
   input wire amg_req_t req, // host register request
   output logic reg_hit, // request address is mapped
   output logic [15:0] reg_rdata, // read data, held until next read
   output amg_path_t aux3_left_to_outmix_left_gain, // third left aux to left out
   output amg_path_t right_amp_to_outmix_left_gain, // right amp to left out
   output amg_path_t left_amp_to_outmix_left_gain, // left amp to left out
   output amg_path_t aux3_right_to_outmix_right_gain, // third right aux to right out
   output amg_path_t right_amp_to_outmix_right_gain, // right amp to right out
   output amg_path_t left_amp_to_outmix_right_gain, // left amp to right out
   output amg_path_t aux3_left_to_recmix_gain, // third left aux to record
   output amg_path_t aux2_left_to_recmix_gain, // second left aux to record
   output logic left_amp_record_boost, // left amp boost enable
   output logic [4:0] left_amp_boost_db // boost in dB, 0 or 20
);

   // stored registers and their next values
   logic [15:0] regs_q [AMG_NREG]; // masked register contents
   logic [15:0] regs_d [AMG_NREG]; // next register contents
   logic [15:0] rdata_d; // next read data
   amg_path_t path_q [AMG_NPATH]; // decoded path state
   amg_path_t path_d [AMG_NPATH]; // next decoded path state
   logic [2:0] code_d [AMG_NPATH]; // code fields of next state
   logic boost_q; // stored boost bit

   // address decode
   // reg_hit ignores the strobes, so a host can probe the map without side effects
   wire sel_outl = (req.addr == AMG_OUTMIX_L_ADDR); // left out mixer
   wire sel_outr = (req.addr == AMG_OUTMIX_R_ADDR); // right out mixer
   wire sel_rec = (req.addr == AMG_RECMIX_L_ADDR); // record mixer
   wire wr_outl = ce && req.wr && sel_outl; // write strobes
   wire wr_outr = ce && req.wr && sel_outr;
   wire wr_rec = ce && req.wr && sel_rec;

   assign reg_hit = sel_outl || sel_outr || sel_rec;

   // next register values; only field bits are kept
   // masking on the way in lets the read mux pass stored words straight out
   assign regs_d[0] = wr_outl ? (req.wdata & AMG_OUTMIX_L_MASK) : regs_q[0];
   assign regs_d[1] = wr_outr ? (req.wdata & AMG_OUTMIX_R_MASK) : regs_q[1];
   assign regs_d[2] = wr_rec ? (req.wdata & AMG_RECMIX_L_MASK) : regs_q[2];

   // read mux, unmapped reads return zero
   // a read beside a write sees the word from before the edge
   assign rdata_d = sel_outl ? regs_q[0] :
                    sel_outr ? regs_q[1] :
                    sel_rec ? regs_q[2] : 16'h0000;

   // field extraction from the next state
   // taken from the next state so the decoded flops land with the word
   assign code_d[0] = regs_d[0][AMG_AUX3L_OUTL_LSB +: AMG_CODE_W];
   assign code_d[1] = regs_d[0][AMG_RAMP_OUTL_LSB +: AMG_CODE_W];
   assign code_d[2] = regs_d[0][AMG_LAMP_OUTL_LSB +: AMG_CODE_W];
   assign code_d[3] = regs_d[1][AMG_AUX3R_OUTR_LSB +: AMG_CODE_W];
   assign code_d[4] = regs_d[1][AMG_RAMP_OUTR_LSB +: AMG_CODE_W];
   assign code_d[5] = regs_d[1][AMG_LAMP_OUTR_LSB +: AMG_CODE_W];
   assign code_d[6] = regs_d[2][AMG_AUX3L_REC_LSB +: AMG_CODE_W];
   assign code_d[7] = regs_d[2][AMG_AUX2L_REC_LSB +: AMG_CODE_W];

   // one decoder per path
   // each instance is pure logic; the flops that hold the result follow below
   for (genvar i = 0; i < AMG_NPATH; i++) begin : g_dec
      assign path_d[i] = amg_decode(code_d[i]);
   end

   // register storage
   // reset wins over the enable, so a held-off clock enable still clears
   always_ff @(posedge mclk) begin
      if (rst) begin
         // all fields reset to path cut, boost off
         for (int r = 0; r < AMG_NREG; r++) begin
            regs_q[r] <= AMG_REG_RST;
         end
      end else if (ce) begin
         for (int r = 0; r < AMG_NREG; r++) begin
            regs_q[r] <= regs_d[r];
         end
      end
   end

   // decoded path state, updated with the codes
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int p = 0; p < AMG_NPATH; p++) begin
            path_q[p] <= '0;
         end
         boost_q <= 1'b0;
      end else if (ce) begin
         for (int p = 0; p < AMG_NPATH; p++) begin
            path_q[p] <= path_d[p];
         end
         boost_q <= regs_d[2][AMG_BOOST_BIT];
      end
   end

   // read data, captured on a read request
   always_ff @(posedge mclk) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else if (ce && req.rd) begin
         reg_rdata <= rdata_d;
      end
   end

   // named path outputs
   // outputs come straight from flops, except left_amp_boost_db, which is muxed from boost_q
   assign aux3_left_to_outmix_left_gain = path_q[0];
   assign right_amp_to_outmix_left_gain = path_q[1];
   assign left_amp_to_outmix_left_gain = path_q[2];
   assign aux3_right_to_outmix_right_gain = path_q[3];
   assign right_amp_to_outmix_right_gain = path_q[4];
   assign left_amp_to_outmix_right_gain = path_q[5];
   assign aux3_left_to_recmix_gain = path_q[6];
   assign aux2_left_to_recmix_gain = path_q[7];
   assign left_amp_record_boost = boost_q;
   assign left_amp_boost_db = boost_q ? AMG_BOOST_ON_DB : AMG_BOOST_OFF_DB;

   // checks on the register bank
   // all checks sample on mclk and sleep through reset unless they say otherwise
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   aux3l_outl_code_a: assert property (wr_outl |=> ##0
      aux3_left_to_outmix_left_gain == amg_decode($past(req.wdata[11:9])))
      else $error("third left aux to left out gain wrong after write");

   ramp_outl_code_a: assert property (wr_outl |=>
      right_amp_to_outmix_left_gain.connected == ($past(req.wdata[7:5]) != 3'h0))
      else $error("right amp to left out connect wrong after write");

   lamp_outl_hold_a: assert property (!wr_outl && ce |=>
      $stable(left_amp_to_outmix_left_gain))
      else $error("left amp to left out gain changed without write");

   aux3r_outr_code_a: assert property (wr_outr |=>
      aux3_right_to_outmix_right_gain == amg_decode($past(req.wdata[15:13])))
      else $error("third right aux to right out gain wrong after write");

   ramp_outr_code_a: assert property (wr_outr |=>
      right_amp_to_outmix_right_gain == amg_decode($past(req.wdata[7:5])))
      else $error("right amp to right out gain wrong after write");

   lamp_outr_code_a: assert property (wr_outr |=>
      left_amp_to_outmix_right_gain == amg_decode($past(req.wdata[3:1])))
      else $error("left amp to right out gain wrong after write");

   aux3l_rec_code_a: assert property (wr_rec |=>
      aux3_left_to_recmix_gain == amg_decode($past(req.wdata[11:9])))
      else $error("third left aux to record gain wrong after write");

   aux2l_rec_code_a: assert property (wr_rec |=>
      aux2_left_to_recmix_gain == amg_decode($past(req.wdata[3:1])))
      else $error("second left aux to record gain wrong after write");

   gain_ends_a: assert property (wr_outl && req.wdata[11:9] == 3'h7 |=>
      aux3_left_to_outmix_left_gain.gain_db == 5'sd6)
      else $error("top gain code does not give plus six dB");

   gain_floor_a: assert property (wr_rec && req.wdata[3:1] == 3'h1 |=>
      aux2_left_to_recmix_gain.gain_db == -5'sd12
      && aux2_left_to_recmix_gain.connected)
      else $error("lowest gain code does not give minus twelve dB");

   gain_step_a: assert property (wr_outr && req.wdata[7:5] == 3'h4 |=>
      right_amp_to_outmix_right_gain.gain_db == -5'sd3)
      else $error("middle gain code off the three dB step");

   boost_write_a: assert property (wr_rec |=>
      left_amp_record_boost == $past(req.wdata[0])
      && left_amp_boost_db == ($past(req.wdata[0]) ? 5'h14 : 5'h00))
      else $error("boost does not follow written bit");

   unused_bits_a: assert property (ce && req.rd && sel_outl |=>
      (reg_rdata & ~AMG_OUTMIX_L_MASK) == 16'h0000)
      else $error("unassigned bits read back non zero");

   readback_a: assert property (wr_rec ##1 (ce && req.rd && sel_rec && !req.wr) |=>
      reg_rdata == ($past(req.wdata, 2) & AMG_RECMIX_L_MASK))
      else $error("record mixer readback does not match write");

   // reset must clear every field, so this one ignores the default disable
   reset_clear_a: assert property (disable iff (1'b0) rst |=>
      reg_rdata == 16'h0000 && !left_amp_record_boost && left_amp_boost_db == 5'h00
      && {aux3_left_to_outmix_left_gain, right_amp_to_outmix_left_gain,
      left_amp_to_outmix_left_gain, aux3_right_to_outmix_right_gain} == '0
      && {right_amp_to_outmix_right_gain, left_amp_to_outmix_right_gain,
      aux3_left_to_recmix_gain, aux2_left_to_recmix_gain} == '0)
      else $error("register state not cleared by reset");

   // a low enable freezes the stored words and the read data alike
   freeze_all_a: assert property (!ce |=> $stable(reg_rdata) && $stable(regs_q[0])
      && $stable(regs_q[1]) && $stable(regs_q[2]) && $stable(left_amp_record_boost))
      else $error("state moved while the clock enable was low");

   // read data only moves on an accepted read
   rdata_hold_a: assert property (!(ce && req.rd) |=> $stable(reg_rdata))
      else $error("read data moved without an accepted read");

   unmapped_read_a: assert property (ce && req.rd && !reg_hit |=>
      reg_rdata == 16'h0000)
      else $error("unmapped read did not return zero");

   // mapped window is 0x60 to 0x62, worked out here from the address bits
   hit_decode_a: assert property (
      reg_hit == (req.addr[7:2] == 6'h18 && req.addr[1:0] != 2'h3))
      else $error("address decode flag wrong");

   // a read in the cycle of a write returns the word from before it
   read_old_a: assert property (ce && req.rd && req.wr && sel_outl |=>
      reg_rdata == $past(regs_q[0]))
      else $error("read beside a write did not return the old word");

   // readback of the output mixer words, spare bits dropped
   outl_readback_a: assert property (
      wr_outl ##1 (ce && req.rd && sel_outl && !req.wr) |=>
      reg_rdata == ($past(req.wdata, 2) & 16'h0EEE))
      else $error("left out mixer readback does not match write");

   outr_readback_a: assert property (
      wr_outr ##1 (ce && req.rd && sel_outr && !req.wr) |=>
      reg_rdata == ($past(req.wdata, 2) & 16'hE0EE))
      else $error("right out mixer readback does not match write");

   spare_outr_a: assert property (ce && req.rd && sel_outr |=>
      (reg_rdata & 16'h1F11) == 16'h0000)
      else $error("right out mixer spare bits read non zero");

   spare_rec_a: assert property (ce && req.rd && sel_rec |=>
      (reg_rdata & 16'hF1F0) == 16'h0000)
      else $error("record mixer spare bits read non zero");

   // gain table, one code per check, figures written out by hand
   gain_cut_a: assert property (wr_outl && req.wdata[11:9] == 3'h0 |=>
      !aux3_left_to_outmix_left_gain.connected
      && aux3_left_to_outmix_left_gain.gain_db == 5'sd0)
      else $error("code zero does not cut the path");

   gain_second_a: assert property (wr_outl && req.wdata[7:5] == 3'h2 |=>
      right_amp_to_outmix_left_gain.gain_db == -5'sd9)
      else $error("second gain code does not give minus nine dB");

   gain_third_a: assert property (wr_outl && req.wdata[11:9] == 3'h3 |=>
      aux3_left_to_outmix_left_gain.gain_db == -5'sd6)
      else $error("third gain code does not give minus six dB");

   gain_unity_a: assert property (wr_outl && req.wdata[11:9] == 3'h5 |=>
      aux3_left_to_outmix_left_gain.gain_db == 5'sd0
      && aux3_left_to_outmix_left_gain.connected)
      else $error("fifth gain code does not give unity gain");

   gain_sixth_a: assert property (wr_outl && req.wdata[11:9] == 3'h6 |=>
      aux3_left_to_outmix_left_gain.gain_db == 5'sd3)
      else $error("sixth gain code does not give plus three dB");

   gain_top_r_a: assert property (wr_outr && req.wdata[15:13] == 3'h7 |=>
      aux3_right_to_outmix_right_gain.gain_db == 5'sd6)
      else $error("top gain code wrong on the right out mixer");

   gain_floor_r_a: assert property (wr_outr && req.wdata[3:1] == 3'h1 |=>
      left_amp_to_outmix_right_gain.gain_db == -5'sd12)
      else $error("lowest gain code wrong on the right out mixer");

   rec_mid_a: assert property (wr_rec && req.wdata[11:9] == 3'h4 |=>
      aux3_left_to_recmix_gain.gain_db == -5'sd3)
      else $error("middle gain code wrong on the record mixer");

   rec_top_a: assert property (wr_rec && req.wdata[3:1] == 3'h7 |=>
      aux2_left_to_recmix_gain.gain_db == 5'sd6)
      else $error("top gain code wrong on the record mixer");

   // fields hold between writes to their own register
   boost_hold_a: assert property (!wr_rec |=> $stable(left_amp_record_boost))
      else $error("boost changed without a write");

   outr_hold_a: assert property (!wr_outr |=> $stable(aux3_right_to_outmix_right_gain)
      && $stable(right_amp_to_outmix_right_gain) && $stable(left_amp_to_outmix_right_gain))
      else $error("right out mixer gain changed without a write");

   rec_hold_a: assert property (!wr_rec |=> $stable(aux3_left_to_recmix_gain)
      && $stable(aux2_left_to_recmix_gain))
      else $error("record mixer gain changed without a write");

endmodule : amg_regs

`default_nettype wire

// >>> hdl/amg_pkg.sv
// Purpose: shared constants and types for the mixer path gain register bank
// Assumes: 16-bit control words, registers indexed by 8-bit address
// Notes: gain codes are three bits, 000 cuts the path
`default_nettype none

package amg_pkg;

   // register addresses on the control interface
   localparam logic [7:0] AMG_OUTMIX_L_ADDR = 8'h60;
   localparam logic [7:0] AMG_OUTMIX_R_ADDR = 8'h61;
   localparam logic [7:0] AMG_RECMIX_L_ADDR = 8'h62;

   // register geometry
   localparam int AMG_DATA_W = 16;
   localparam int AMG_CODE_W = 3;
   localparam int AMG_NREG = 3;
   localparam int AMG_NPATH = 8;

   // field positions (low bit of each code)
   localparam int AMG_AUX3L_OUTL_LSB = 9;
   localparam int AMG_RAMP_OUTL_LSB = 5;
   localparam int AMG_LAMP_OUTL_LSB = 1;
   localparam int AMG_AUX3R_OUTR_LSB = 13;
   localparam int AMG_RAMP_OUTR_LSB = 5;
   localparam int AMG_LAMP_OUTR_LSB = 1;
   localparam int AMG_AUX3L_REC_LSB = 9;
   localparam int AMG_AUX2L_REC_LSB = 1;
   localparam int AMG_BOOST_BIT = 0;

   // writable bits per register, the rest read as zero
   localparam logic [15:0] AMG_OUTMIX_L_MASK = 16'h0EEE;
   localparam logic [15:0] AMG_OUTMIX_R_MASK = 16'hE0EE;
   localparam logic [15:0] AMG_RECMIX_L_MASK = 16'h0E0F;

   // reset values
   localparam logic [15:0] AMG_REG_RST = 16'h0000;
   localparam logic [2:0] AMG_CODE_OFF = 3'h0;

   // gain law: code 001 is the floor, each code above adds a step
   localparam logic signed [4:0] AMG_GAIN_MIN_DB = -5'sd12;
   localparam logic signed [4:0] AMG_GAIN_STEP_DB = 5'sd3;
   localparam logic [4:0] AMG_BOOST_ON_DB = 5'h14;
   localparam logic [4:0] AMG_BOOST_OFF_DB = 5'h00;

   // host request carrier
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } amg_req_t;

   // decoded state of one mixer path
   typedef struct packed {
      logic connected;
      logic signed [4:0] gain_db;
   } amg_path_t;

   // turn a three-bit code into connect flag and gain in dB
   function automatic amg_path_t amg_decode(input logic [2:0] code);
      amg_path_t p;
      logic signed [4:0] steps;
      steps = signed'({2'b00, code - 3'h1});
      p.connected = (code != AMG_CODE_OFF);
      p.gain_db = p.connected ? (AMG_GAIN_MIN_DB + AMG_GAIN_STEP_DB * steps) : 5'sd0;
      return p;
   endfunction : amg_decode

endpackage : amg_pkg

`default_nettype wire

// >>> tb/amg_regs_tb.sv
// Purpose: self-checking bench for the mixer path gain register bank
// Assumes: one access per cycle, results read 1 ns after the edge that takes the request
// Notes: inputs change 1 ns after each rising edge
`default_nettype none

module amg_regs_tb
   import amg_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   logic mclk; // bench clock
   logic rst; // synchronous reset
   logic ce; // clock enable
   amg_req_t req; // host request
   logic reg_hit; // address decode
   logic [15:0] reg_rdata; // read data
   amg_path_t pth [8]; // decoded paths in port order
   logic boost; // boost flag
   logic [4:0] boost_db; // boost in dB
   int n_mismatch = 0; // failed compares
   int n_compared = 0; // all compares
   logic hit; // decode seen in the last request cycle

   amg_regs DUT (.mclk(mclk), .rst(rst), .ce(ce), .req(req), .reg_hit(reg_hit),
      .reg_rdata(reg_rdata), .aux3_left_to_outmix_left_gain(pth[0]),
      .right_amp_to_outmix_left_gain(pth[1]), .left_amp_to_outmix_left_gain(pth[2]),
      .aux3_right_to_outmix_right_gain(pth[3]), .right_amp_to_outmix_right_gain(pth[4]),
      .left_amp_to_outmix_right_gain(pth[5]), .aux3_left_to_recmix_gain(pth[6]),
      .aux2_left_to_recmix_gain(pth[7]), .left_amp_record_boost(boost),
      .left_amp_boost_db(boost_db));

   // 200 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // count and report one word compare
   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp16

   // count and report one decoded path compare
   task automatic cmp_path(input amg_path_t got, input amg_path_t exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp_path

   // expected decode: 000 cut, else -12dB plus 3dB per code step
   function automatic amg_path_t ep(input logic [2:0] c);
      amg_path_t p;
      p.connected = (c != 3'h0);
      p.gain_db = (c == 3'h0) ? 5'sd0 : 5'(3 * int'(c) - 15);
      return p;
   endfunction : ep

   // one request cycle; decode sampled before the edge takes it
   task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
      req = '{wr: w, rd: r, addr: a, wdata: d};
      #1 hit = reg_hit;
      @(posedge mclk);
      #1;
   endtask : op

   // registers and outputs come up cleared
   task automatic t_reset();
      for (int i = 0; i < 3; i++) begin
         op(1'b0, 1'b1, 8'h60 + 8'(i), 16'h0000);
         cmp16(reg_rdata, 16'h0000);
      end
      for (int i = 0; i < 8; i++) cmp_path(pth[i], ep(3'h0));
      cmp16({10'h000, boost, boost_db}, 16'h0000);
   endtask : t_reset

   // every code in every field, neighbours hold different codes
   task automatic t_sweep();
      logic [2:0] a, b, d;
      for (int c = 0; c < 8; c++) begin
         a = 3'(c);
         b = a + 3'h1;
         d = a + 3'h2;
         op(1'b1, 1'b0, 8'h60, {4'h0, a, 1'b0, b, 1'b0, d, 1'b0});
         op(1'b1, 1'b0, 8'h61, {a, 5'h00, b, 1'b0, d, 1'b0});
         op(1'b1, 1'b0, 8'h62, {4'h0, a, 5'h00, b, a[0]});
         op(1'b0, 1'b1, 8'h62, 16'h0000);
         cmp_path(pth[0], ep(a));
         cmp_path(pth[1], ep(b));
         cmp_path(pth[2], ep(d));
         cmp_path(pth[3], ep(a));
         cmp_path(pth[4], ep(b));
         cmp_path(pth[5], ep(d));
         cmp_path(pth[6], ep(a));
         cmp_path(pth[7], ep(b));
         cmp16({10'h000, boost, boost_db}, {10'h000, a[0], a[0] ? 5'h14 : 5'h00});
         cmp16(reg_rdata, {4'h0, a, 5'h00, b, a[0]});
      end
   endtask : t_sweep

   // spare bits dropped, unmapped and disabled writes ignored
   task automatic t_masks();
      logic [15:0] exp [3] = '{16'h0EEE, 16'hE0EE, 16'h0E0F};
      for (int i = 0; i < 3; i++) begin
         op(1'b1, 1'b0, 8'h60 + 8'(i), 16'hFFFF);
         op(1'b0, 1'b1, 8'h60 + 8'(i), 16'h0000);
         cmp16(reg_rdata, exp[i]);
      end
      cmp16({15'h0000, hit}, 16'h0001);
      op(1'b1, 1'b0, 8'h63, 16'h0000);
      cmp16({15'h0000, hit}, 16'h0000);
      ce = 1'b0;
      op(1'b1, 1'b0, 8'h60, 16'h0000);
      ce = 1'b1;
      op(1'b1, 1'b1, 8'h60, 16'h0002);
      cmp16(reg_rdata, 16'h0EEE);
      cmp_path(pth[2], ep(3'h1));
      op(1'b0, 1'b1, 8'h5F, 16'h0000);
      cmp16(reg_rdata, 16'h0000);
   endtask : t_masks

   // second reset in mid-run clears a live boost
   task automatic t_rereset();
      rst = 1'b1;
      op(1'b0, 1'b0, 8'h00, 16'h0000);
      rst = 1'b0;
      op(1'b0, 1'b1, 8'h62, 16'h0000);
      cmp16(reg_rdata, 16'h0000);
      cmp16({10'h000, boost, boost_db}, 16'h0000);
      cmp_path(pth[2], ep(3'h0));
   endtask : t_rereset

   // print the counts and the verdict, then stop
   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish

   // watchdog against a hung run
   initial begin
      #50us;
      n_mismatch++;
      tally_and_finish();
   end

   // main sequence
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      req = '0;
      hit = 1'b0;
      repeat (20) @(posedge mclk);
      #1 rst = 1'b0;
      t_reset();
      t_sweep();
      t_masks();
      t_rereset();
      tally_and_finish();
   end

endmodule : amg_regs_tb

`default_nettype wire
